// file: mic_regs.vh
// register map, bit positions and constants of the interrupt controller
`ifndef MIC_REGS_VH
`define MIC_REGS_VH

// register indices as printed; byte address is four times the index
`define MIC_IDX_CTRL      8'h0b
`define MIC_IDX_PFLAG     8'h0c
`define MIC_IDX_PEN       8'h8c
`define MIC_IDX_OPT       8'h81
`define MIC_IDX_PINEN     8'h96
`define MIC_IDX_CORE      8'hf0
`define MIC_IDX_STAT      8'hf1
`define MIC_IDX_PWR       8'hf2

`define MIC_CTRL_RST      8'h00
`define MIC_PFLAG_RST     8'h00
`define MIC_PEN_RST       8'h00
`define MIC_OPT_RST       8'hff
`define MIC_PINEN_RST     6'h00
`define MIC_STAT_RST      8'h18
`define MIC_PWR_RST       4'h2

// control register bits, and the edge select bit of the option register
`define MIC_B_GIE         7
`define MIC_B_PERIPHERAL_IRQ_ENABLE        6
`define MIC_B_T0E         5
`define MIC_B_EXTE        4
`define MIC_B_PCE         3
`define MIC_B_T0F         2
`define MIC_B_EXTF        1
`define MIC_B_PCF         0
`define MIC_B_EDGE        6

`define MIC_VECTOR        13'h0004
`define MIC_PC_ZERO       13'h0000
`define MIC_STAT_MASTER_CLEAR_NRM 8'h1f
`define MIC_STAT_SLP_SET  8'h10
`define MIC_STAT_SLP_MASK 8'h07
`define MIC_PWR_KEEP      4'h7
`define MIC_PORT_W        6
`define MIC_LAT_CYC       2'h2
`define MIC_Q_LAST        2'h3
`define MIC_Q2            2'h1
`define MIC_Q4            2'h3
`define MIC_Q1            2'h0

`endif

// file: mic_irq_ctrl.v
// interrupt controller of a small microcontroller with an avalon-mm register slave
//
// Function
// - eleven sources: eight peripheral, three core flags
// - global enable gates all; cleared by reset
// - entry clears global enable, pushes, vectors
// - return instruction sets global enable again
// - pin/port latency three or four cycles
// - flags set regardless of interrupt enables; port flag needs a pin enable
// - requests after global clear stay pending
// - edge select picks rising or falling edge
// - pin enable masks; enabled edge wakes core
// - pin flag may set during Q4-Q1
// - timer overflow sets flag, masked by bit5
// - port change flag, per-pin enable register
// - change during port read may be missed
// - peripheral flags and enables share layout
// - normal master clear: pc zero, status/power
// - sleep master clear: pc zero, status pattern
// - wake continues next; vectors after it
// - only return pc saved on stack
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mic_regs.vh"

module mic_irq_ctrl (
   input  wire        clk_i,
   input  wire        rst_n_i,
   // avalon-mm slave
   input  wire [9:0]  avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   input  wire [3:0]  avs_byteenable_i,
   output reg  [31:0] avs_readdata_o,
   output wire        avs_waitrequest_o,
   output reg  [1:0]  avs_response_o,
   // sources
   input  wire        external_irq_pin_i,
   input  wire        timer_zero_overflow_i,
   input  wire [5:0]  port_a_inputs_i,
   input  wire [7:0]  periph_event_i,
   // core side
   input  wire        master_clear_i,
   input  wire        sleeping_i,
   input  wire        instr_cycle_end_i,
   input  wire        return_from_irq_instr_i,
   input  wire        global_clear_instr_i,
   input  wire [12:0] pc_i,
   output reg  [1:0]  quarter_phase_o,
   output wire        core_irq_o,
   output wire        wake_o,
   output reg         vector_load_o,
   output reg  [12:0] vector_addr_o,
   output reg         stack_push_o,
   output reg  [12:0] stack_push_data_o,
   output reg  [12:0] pc_reset_o,
   output reg         pc_reset_load_o
);

   reg  [7:0]  ctrl_reg;
   reg  [7:0]  pflag_reg;
   reg  [7:0]  pen_reg;
   reg  [7:0]  opt_reg;
   reg  [5:0]  pinen_reg;
   reg  [7:0]  stat_reg;
   reg  [3:0]  pwr_reg;
   reg         pin_prev_reg;
   reg  [5:0]  port_prev_reg;
   reg         ack_reg;
   reg  [1:0]  lat_reg;
   reg         pend_reg;
   reg         hold_reg;
   reg         wake_seen_reg;
   reg         master_clear_prev_reg;

   wire        access   = avs_read_i | avs_write_i;
   wire [7:0]  idx      = avs_address_i[9:2];
   wire        wr       = avs_write_i & ack_reg & avs_byteenable_i[0];
   wire [7:0]  wdat     = avs_writedata_i[7:0];

   // one wait state, answer on second cycle
   assign avs_waitrequest_o = access & ~ack_reg;

   wire        edge_sel  = opt_reg[`MIC_B_EDGE];
   wire        pin_rise  = external_irq_pin_i & ~pin_prev_reg;
   wire        pin_fall  = ~external_irq_pin_i & pin_prev_reg;
   wire        q_window  = (quarter_phase_o == `MIC_Q4) | (quarter_phase_o == `MIC_Q1);
   wire        pin_ev    = (edge_sel ? pin_rise : pin_fall) & q_window;
   // a change landing on the port read phase is missed
   wire        port_ev   = |((port_a_inputs_i ^ port_prev_reg) & pinen_reg)
                           & (quarter_phase_o != `MIC_Q2);

   wire        core_hit  = (ctrl_reg[`MIC_B_T0E] & ctrl_reg[`MIC_B_T0F])
                         | (ctrl_reg[`MIC_B_EXTE] & ctrl_reg[`MIC_B_EXTF])
                         | (ctrl_reg[`MIC_B_PCE] & ctrl_reg[`MIC_B_PCF]);
   wire        periph_hit = ctrl_reg[`MIC_B_PERIPHERAL_IRQ_ENABLE] & |(pflag_reg & pen_reg);
   assign wake_o     = core_hit | periph_hit;
   assign core_irq_o = wake_o & ctrl_reg[`MIC_B_GIE] & ~hold_reg;

   // register read mux
   always @* begin
      avs_readdata_o = 32'h0000_0000;
      avs_response_o = 2'h0;
      if (idx == `MIC_IDX_CTRL) begin
         avs_readdata_o[7:0] = ctrl_reg;
      end else if (idx == `MIC_IDX_PFLAG) begin
         avs_readdata_o[7:0] = pflag_reg;
      end else if (idx == `MIC_IDX_PEN) begin
         avs_readdata_o[7:0] = pen_reg;
      end else if (idx == `MIC_IDX_OPT) begin
         avs_readdata_o[7:0] = opt_reg;
      end else if (idx == `MIC_IDX_PINEN) begin
         avs_readdata_o[5:0] = pinen_reg;
      end else if (idx == `MIC_IDX_CORE) begin
         avs_readdata_o[12:0] = pc_i;
         avs_readdata_o[16]   = pend_reg;
         avs_readdata_o[17]   = core_irq_o;
      end else if (idx == `MIC_IDX_STAT) begin
         avs_readdata_o[7:0] = stat_reg;
      end else if (idx == `MIC_IDX_PWR) begin
         avs_readdata_o[3:0] = pwr_reg;
      end else begin
         avs_response_o = 2'h2;
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= access & ~ack_reg;
      end
   end

   // quarter phase counter, last phase ends the instruction cycle
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         quarter_phase_o <= `MIC_Q1;
      end else if (instr_cycle_end_i) begin
         quarter_phase_o <= `MIC_Q1;
      end else begin
         quarter_phase_o <= quarter_phase_o + 2'h1;
      end
   end

   // control register: hardware set beats software clear
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_reg     <= `MIC_CTRL_RST;
         pin_prev_reg <= 1'b0;
         port_prev_reg <= `MIC_PINEN_RST;
      end else begin
         pin_prev_reg  <= external_irq_pin_i;
         port_prev_reg <= port_a_inputs_i;
         if (wr && idx == `MIC_IDX_CTRL) begin
            ctrl_reg <= wdat;
         end
         if (vector_load_o) begin
            ctrl_reg[`MIC_B_GIE] <= 1'b0;
         end else if (return_from_irq_instr_i) begin
            ctrl_reg[`MIC_B_GIE] <= 1'b1;
         end else if (global_clear_instr_i) begin
            ctrl_reg[`MIC_B_GIE] <= 1'b0;
         end
         if (timer_zero_overflow_i) begin
            ctrl_reg[`MIC_B_T0F] <= 1'b1;
         end
         if (pin_ev) begin
            ctrl_reg[`MIC_B_EXTF] <= 1'b1;
         end
         if (port_ev) begin
            ctrl_reg[`MIC_B_PCF] <= 1'b1;
         end
      end
   end

   // peripheral flags, one per source
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_pflag
         always @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               pflag_reg[g] <= 1'b0;
            end else if (periph_event_i[g]) begin
               pflag_reg[g] <= 1'b1;
            end else if (wr && idx == `MIC_IDX_PFLAG) begin
               pflag_reg[g] <= wdat[g];
            end
         end
      end
   endgenerate

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pen_reg   <= `MIC_PEN_RST;
         opt_reg   <= `MIC_OPT_RST;
         pinen_reg <= `MIC_PINEN_RST;
      end else if (wr) begin
         if (idx == `MIC_IDX_PEN) begin
            pen_reg <= wdat;
         end else if (idx == `MIC_IDX_OPT) begin
            opt_reg <= wdat;
         end else if (idx == `MIC_IDX_PINEN) begin
            pinen_reg <= wdat[5:0];
         end
      end
   end

   // service sequencer: fixed latency in instruction cycles, only one after a wake
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lat_reg           <= 2'h0;
         pend_reg          <= 1'b0;
         hold_reg          <= 1'b0;
         wake_seen_reg     <= 1'b0;
         vector_load_o     <= 1'b0;
         vector_addr_o     <= `MIC_PC_ZERO;
         stack_push_o      <= 1'b0;
         stack_push_data_o <= `MIC_PC_ZERO;
      end else begin
         vector_load_o <= 1'b0;
         stack_push_o  <= 1'b0;
         // ignore requests after a global clear until the instruction cycle ends
         if (global_clear_instr_i) begin
            hold_reg <= 1'b1;
         end else if (instr_cycle_end_i) begin
            hold_reg <= 1'b0;
         end
         // wake: run the next instruction before vectoring
         if (sleeping_i && wake_o) begin
            wake_seen_reg <= 1'b1;
         end
         if (core_irq_o && !pend_reg && !sleeping_i && instr_cycle_end_i) begin
            pend_reg <= 1'b1;
            lat_reg  <= wake_seen_reg ? 2'h0 : `MIC_LAT_CYC;
         end else if (pend_reg && instr_cycle_end_i) begin
            if (lat_reg != 2'h0) begin
               lat_reg <= lat_reg - 2'h1;
            end else begin
               pend_reg          <= 1'b0;
               wake_seen_reg     <= 1'b0;
               vector_load_o     <= 1'b1;
               vector_addr_o     <= `MIC_VECTOR;
               stack_push_o      <= 1'b1;
               stack_push_data_o <= pc_i;
            end
         end else if (pend_reg && !ctrl_reg[`MIC_B_GIE]) begin
            pend_reg <= 1'b0;
         end
      end
   end

   // status and power bits under master clear
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stat_reg        <= `MIC_STAT_RST;
         pwr_reg         <= `MIC_PWR_RST;
         pc_reset_o      <= `MIC_PC_ZERO;
         pc_reset_load_o <= 1'b0;
         master_clear_prev_reg   <= 1'b0;
      end else begin
         master_clear_prev_reg   <= master_clear_i;
         pc_reset_load_o <= 1'b0;
         if (wr && idx == `MIC_IDX_STAT) begin
            stat_reg <= wdat;
         end
         if (wr && idx == `MIC_IDX_PWR) begin
            pwr_reg <= wdat[3:0];
         end
         if (master_clear_i && !master_clear_prev_reg) begin
            pc_reset_o      <= `MIC_PC_ZERO;
            pc_reset_load_o <= 1'b1;
            pwr_reg         <= pwr_reg & `MIC_PWR_KEEP;
            if (sleeping_i) begin
               stat_reg <= (stat_reg & `MIC_STAT_SLP_MASK) | `MIC_STAT_SLP_SET;
            end else begin
               stat_reg <= stat_reg & `MIC_STAT_MASTER_CLEAR_NRM;
            end
         end
      end
   end

endmodule
`default_nettype wire

// file: mic_irq_props_properties.sv
// port checks of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module mic_irq_props (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic        avs_waitrequest_o,
   input wire logic        instr_cycle_end_i,
   input wire logic        return_from_irq_instr_i,
   input wire logic        global_clear_instr_i,
   input wire logic        core_irq_o,
   input wire logic        wake_o,
   input wire logic        vector_load_o,
   input wire logic [12:0] vector_addr_o,
   input wire logic        stack_push_o,
   input wire logic        pc_reset_load_o,
   input wire logic [12:0] pc_reset_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   a_irq_needs_wake: assert property (core_irq_o |-> wake_o)
      else $error("request without wake");
   a_vector_pushes: assert property (vector_load_o |-> stack_push_o && vector_addr_o == 13'h0004)
      else $error("vector without push");
   a_vector_single: assert property (vector_load_o |=> !vector_load_o)
      else $error("vector pulse too long");
   a_vector_after_end: assert property (vector_load_o |-> $past(instr_cycle_end_i))
      else $error("vector off cycle end");
   a_vector_clears_gie: assert property (vector_load_o |=> !core_irq_o)
      else $error("request after vector");
   a_return_sets_gie: assert property (return_from_irq_instr_i && wake_o && !avs_write_i
      && !global_clear_instr_i |=> core_irq_o)
      else $error("return left request off");
   a_clear_masks_irq: assert property (global_clear_instr_i && !return_from_irq_instr_i
      |=> !core_irq_o)
      else $error("request after global clear");
   a_reset_pc_zero: assert property (pc_reset_load_o |-> pc_reset_o == 13'h0000)
      else $error("reset pc not zero");
   a_one_wait_state: assert property ($rose(avs_read_i || avs_write_i)
      |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("wait state count");
endmodule
`default_nettype wire

// file: mic_core_model.sv
// processor core model: instruction cycle ends and program counter
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        vector_load_i,
   input  wire logic [12:0] vector_addr_i,
   output wire logic        instr_cycle_end_o,
   output var  logic [12:0] pc_o
);
   logic [1:0] q_reg;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_reg <= 2'h0;
         pc_o <= 13'h0000;
      end else begin
         q_reg <= q_reg + 2'h1;
         if (vector_load_i) begin
            pc_o <= vector_addr_i;
         end else if (q_reg == 2'h3) begin
            pc_o <= pc_o + 13'h0001;
         end
      end
   end
   assign instr_cycle_end_o = (q_reg == 2'h3);
endmodule
`default_nettype wire

// file: mic_irq_ctrl_tb.sv
// self-checking testbench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl_tb;
   logic        clk_i = 0, rst_n_i = 0, rd = 0, wr = 0, pin = 0, t0 = 0, master_clear = 0, slp = 0;
   logic        ret = 0, gclr = 0, cend, waitreq, irq, wake, vld, push, pcl;
   logic [9:0]  adr = 0;
   logic [31:0] wdat = 0, rdata, rdv, v, rs = 32'h0000_1326;
   logic [7:0]  pev = 0;
   logic [7:0]  ridx [7] = '{8'h0b, 8'h0c, 8'h8c, 8'h81, 8'h96, 8'hf1, 8'hf2};
   logic [5:0]  port = 0;
   logic [1:0]  resp, rsp, qph;
   logic [12:0] pc, vadr, pdat, pcr;
   int          fails = 0, checks = 0, pcl_n = 0;
   int          mdl [256];
   mic_irq_ctrl mic_irq_ctrl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'h1),
      .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .avs_response_o(resp),
      .external_irq_pin_i(pin), .timer_zero_overflow_i(t0), .port_a_inputs_i(port),
      .periph_event_i(pev), .master_clear_i(master_clear), .sleeping_i(slp), .instr_cycle_end_i(cend),
      .return_from_irq_instr_i(ret), .global_clear_instr_i(gclr), .pc_i(pc),
      .quarter_phase_o(qph), .core_irq_o(irq), .wake_o(wake), .vector_load_o(vld),
      .vector_addr_o(vadr), .stack_push_o(push), .stack_push_data_o(pdat), .pc_reset_o(pcr),
      .pc_reset_load_o(pcl));
   mic_core_model mic_core_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .vector_load_i(vld),
      .vector_addr_i(vadr), .instr_cycle_end_o(cend), .pc_o(pc));
   initial forever #5 clk_i = ~clk_i;
   // count pc reset pulses driven by the design
   always @(posedge clk_i) begin
      if (pcl === 1'b1) pcl_n++;
   end
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      adr <= {idx, 2'b00};
      wdat <= {24'h0, d};
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk_i);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      if (n == 50) fails++;
      rdv = rdata;
      rsp = resp;
      wr <= 0;
      rd <= 0;
      if (w) mdl[idx] = d;
   endtask
   task automatic rdc(input logic [7:0] idx);
      bus(0, idx, 0);
      chk(rdv, mdl[idx]);
   endtask
   task automatic pls(input logic [7:0] e, input logic t, r, g);
      @(posedge clk_i);
      pev <= e;
      t0 <= t;
      ret <= r;
      gclr <= g;
      @(posedge clk_i);
      pev <= 0;
      t0 <= 0;
      ret <= 0;
      gclr <= 0;
   endtask
   task automatic q4;
      do @(posedge clk_i); while (qph !== 2'h3);
   endtask
   task automatic wv;
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (vld !== 1'b1 && n < 100);
      chk({vld, push, vadr, qph}, {2'b11, 13'h0004, 2'h0});
      chk(pdat, pc - 13'h0001);
   endtask
   task automatic complete_run;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      foreach (mdl[i]) mdl[i] = 0;
      mdl[8'h81] = 8'hff;
      mdl[8'hf1] = 8'h18;
      mdl[8'hf2] = 2;
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1;
      foreach (ridx[i]) rdc(ridx[i]);
      bus(0, 8'h10, 0);
      chk({rsp, rdv}, {2'h2, 32'h0});
      $display("test reset done");
      v = xs();
      pls(v[7:0], 1, 0, 0);
      mdl[8'h0c] = v[7:0];
      mdl[8'h0b] = 4;
      rdc(8'h0c);
      rdc(8'h0b);
      bus(1, 8'h0c, 0);
      rdc(8'h0c);
      slp <= 1;
      for (int e = 0; e < 2; e++) begin
         bus(1, 8'h81, {1'b1, e[0], 6'h3f});
         pin <= e[0];
         repeat (8) @(posedge clk_i);
         bus(1, 8'h0b, 8'h10);
         pin <= !e[0];
         repeat (8) @(posedge clk_i);
         rdc(8'h0b);
         q4;
         pin <= e[0];
         repeat (8) @(posedge clk_i);
         mdl[8'h0b] = 8'h12;
         rdc(8'h0b);
         chk({irq, wake}, 2'b01);
      end
      slp <= 0;
      bus(1, 8'h0b, 0);
      bus(1, 8'h96, 8'h01);
      q4;
      port <= 6'h3e;
      repeat (8) @(posedge clk_i);
      rdc(8'h0b);
      q4;
      port <= 6'h3f;
      repeat (8) @(posedge clk_i);
      mdl[8'h0b] = 1;
      rdc(8'h0b);
      $display("test sources done");
      bus(1, 8'h0b, 0);
      bus(1, 8'h8c, 8'h01);
      pls(8'h01, 0, 0, 0);
      bus(1, 8'h0b, 8'h80);
      #1;
      chk({irq, wake}, 0);
      bus(1, 8'h0b, 8'hc0);
      wv;
      mdl[8'h0b] = 8'h40;
      rdc(8'h0b);
      pls(0, 0, 1, 0);
      wv;
      bus(1, 8'h0c, 0);
      pls(0, 0, 1, 0);
      mdl[8'h0b] = 8'hc0;
      rdc(8'h0b);
      pls(8'h01, 0, 0, 1);
      #1;
      chk(irq, 0);
      bus(1, 8'h0b, 8'h40);
      mdl[8'h0c] = 1;
      rdc(8'h0c);
      bus(1, 8'h0b, 8'hc0);
      wv;
      $display("test vector done");
      for (int s = 0; s < 2; s++) begin
         @(posedge clk_i);
         slp <= s[0];
         master_clear <= 1;
         repeat (4) @(posedge clk_i);
         chk(pcr, 0);
         mdl[8'hf1] = s ? 8'h10 : 8'h18;
         rdc(8'hf1);
         rdc(8'hf2);
         master_clear <= 0;
      end
      chk(pcl_n, 2);
      $display("test master clear done");
      complete_run;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      complete_run;
   end
endmodule
bind mic_irq_ctrl mic_irq_props mic_irq_props_inst (.clk_i, .rst_n_i, .avs_read_i, .avs_write_i,
   .avs_waitrequest_o, .instr_cycle_end_i, .return_from_irq_instr_i, .global_clear_instr_i,
   .core_irq_o, .wake_o, .vector_load_o, .vector_addr_o, .stack_push_o, .pc_reset_load_o,
   .pc_reset_o);
`default_nettype wire
